// ### src/slcd_pkg.sv
// Constants and types for the segment LCD status, interrupt and blink block
package slcd_pkg;
  // Bus geometry
  localparam int SLCD_ADR_W = 8;
  localparam int SLCD_DAT_W = 32;
  localparam int SLCD_SEG_W = 40;

  // Register byte offsets
  localparam logic [7:0] SLCD_OFF_CONTROL = 8'h00;
  localparam logic [7:0] SLCD_OFF_DISPLAY = 8'h04;
  localparam logic [7:0] SLCD_OFF_STATE = 8'h08;
  localparam logic [7:0] SLCD_OFF_IRQ_SET = 8'h0c;
  localparam logic [7:0] SLCD_OFF_IRQ_CLR = 8'h10;
  localparam logic [7:0] SLCD_OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] SLCD_OFF_IRQ_PEND = 8'h18;

  // Field positions
  localparam int SLCD_CTRL_EN_BIT = 0;
  localparam int SLCD_STATE_EN_BIT = 0;
  localparam int SLCD_IRQ_FRAME_BIT = 0;
  localparam int SLCD_IRQ_DIS_BIT = 2;
  localparam int SLCD_STYLE_LSB = 0;
  localparam int SLCD_STYLE_W = 3;
  localparam int SLCD_BLINK_LSB = 8;
  localparam int SLCD_BLINK_W = 8;

  // Reset values
  localparam logic SLCD_CTRL_EN_RST = 1'b0;
  localparam logic [7:0] SLCD_BLINK_RST = 8'h00;
  localparam logic [2:0] SLCD_STYLE_RST = 3'h0;
  localparam logic [1:0] SLCD_IRQ_RST = 2'h0;

  // Display styles
  typedef enum logic [2:0] {
    SLCD_STYLE_NORMAL = 3'b000,
    SLCD_STYLE_OFF = 3'b001,
    SLCD_STYLE_ON = 3'b010,
    SLCD_STYLE_BLINK = 3'b011,
    SLCD_STYLE_INVERT = 3'b100,
    SLCD_STYLE_INV_BLINK = 3'b101,
    SLCD_STYLE_USER_ONLY = 3'b110,
    SLCD_STYLE_SWAP = 3'b111
  } slcd_style_t;
endpackage

// ### src/slcd_status_irq.sv
// Segment LCD status, interrupt and blink-rate block with a Wishbone slave
`timescale 1ns/1ps

module slcd_status_irq
  import slcd_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [SLCD_ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [SLCD_DAT_W-1:0] dat_i,
  output logic [SLCD_DAT_W-1:0] dat_o,
  output logic ack_o,
  // Display side
  input wire logic frame_end_i,
  input wire logic [SLCD_SEG_W-1:0] seg_data_i,
  output logic [SLCD_SEG_W-1:0] seg_out_o,
  output logic blink_phase_o,
  output logic enabled_o,
  // Interrupt
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Style decode
  function automatic logic [SLCD_SEG_W-1:0] styled(
    input logic [2:0] style,
    input logic phase,
    input logic [SLCD_SEG_W-1:0] pat
  );
    logic [SLCD_SEG_W-1:0] res;
    res = pat;
    case (style)
      SLCD_STYLE_NORMAL: res = pat;
      SLCD_STYLE_OFF: res = '0;
      SLCD_STYLE_ON: res = '1;
      SLCD_STYLE_BLINK: res = phase ? '0 : pat;
      SLCD_STYLE_INVERT: res = ~pat;
      SLCD_STYLE_INV_BLINK: res = phase ? '0 : ~pat;
      default: res = pat;
    endcase
    return res;
  endfunction

  // Exact byte-address match
  function automatic logic adr_hit(
    input logic [SLCD_ADR_W-1:0] adr,
    input logic [7:0] off
  );
    return adr == off;
  endfunction

  // One flag placed at its bit position
  function automatic logic [SLCD_DAT_W-1:0] flag_at(
    input int pos,
    input logic b
  );
    logic [SLCD_DAT_W-1:0] res;
    res = '0;
    res[pos] = b;
    return res;
  endfunction

  // Interrupt word, packed as {disable, frame end}
  function automatic logic [SLCD_DAT_W-1:0] irq_word(
    input logic [1:0] flags
  );
    return flag_at(SLCD_IRQ_FRAME_BIT, flags[0]) | flag_at(SLCD_IRQ_DIS_BIT, flags[1]);
  endfunction

  // Display register word
  function automatic logic [SLCD_DAT_W-1:0] disp_word(
    input logic [SLCD_BLINK_W-1:0] divider,
    input logic [SLCD_STYLE_W-1:0] style
  );
    logic [SLCD_DAT_W-1:0] res;
    res = '0;
    res[SLCD_BLINK_LSB +: SLCD_BLINK_W] = divider;
    res[SLCD_STYLE_LSB +: SLCD_STYLE_W] = style;
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic ack_reg;
  logic [SLCD_DAT_W-1:0] rdata_reg;
  logic ctrl_en_reg;
  logic [SLCD_BLINK_W-1:0] blink_divider_reg;
  logic [SLCD_STYLE_W-1:0] style_reg;
  logic enabled_state_reg;
  logic [1:0] mask_reg;
  logic [1:0] pend_reg;
  logic [SLCD_STYLE_W-1:0] style_active_reg;
  logic [SLCD_BLINK_W-1:0] frame_cnt_reg;
  logic phase_reg;
  logic [SLCD_SEG_W-1:0] seg_reg;

  wire req = cyc_i & stb_i & ~ack_reg;
  wire wr = req & we_i;
  wire rd = req & ~we_i;
  wire hit_ctrl = adr_hit(adr_i, SLCD_OFF_CONTROL);
  wire hit_disp = adr_hit(adr_i, SLCD_OFF_DISPLAY);
  wire hit_state = adr_hit(adr_i, SLCD_OFF_STATE);
  wire hit_set = adr_hit(adr_i, SLCD_OFF_IRQ_SET);
  wire hit_clr = adr_hit(adr_i, SLCD_OFF_IRQ_CLR);
  wire hit_mask = adr_hit(adr_i, SLCD_OFF_IRQ_MASK);
  wire hit_pend = adr_hit(adr_i, SLCD_OFF_IRQ_PEND);

  // Source bits of a set or clear write, packed as {disable, frame end}
  wire [1:0] wr_bits = sel_i[0] ? {dat_i[SLCD_IRQ_DIS_BIT], dat_i[SLCD_IRQ_FRAME_BIT]} : 2'h0;
  wire [1:0] set_bits = (wr & hit_set) ? wr_bits : 2'h0;
  wire [1:0] clr_bits = (wr & hit_clr) ? wr_bits : 2'h0;
  wire pend_read = rd & hit_pend;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  // Write-only and unmapped offsets fall through to zero
  wire [SLCD_DAT_W-1:0] word_ctrl = flag_at(SLCD_CTRL_EN_BIT, ctrl_en_reg);
  wire [SLCD_DAT_W-1:0] word_disp = disp_word(blink_divider_reg, style_reg);
  wire [SLCD_DAT_W-1:0] word_state = flag_at(SLCD_STATE_EN_BIT, enabled_state_reg);
  wire [SLCD_DAT_W-1:0] word_mask = irq_word(mask_reg);
  wire [SLCD_DAT_W-1:0] word_pend = irq_word(pend_reg);
  wire [SLCD_DAT_W-1:0] rmux =
    hit_ctrl ? word_ctrl :
    hit_disp ? word_disp :
    hit_state ? word_state :
    hit_mask ? word_mask :
    hit_pend ? word_pend : '0;

  // Bus answer
  wire ack_next = req;
  wire [SLCD_DAT_W-1:0] rdata_next = rd ? rmux : '0;

  // One idle cycle follows every ack, so a held strobe is not taken twice
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
    end
  end

  // Data is zero outside the ack cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  wire ctrl_wr = wr & hit_ctrl & sel_i[0];
  wire disp_hi_wr = wr & hit_disp & sel_i[1];
  wire disp_lo_wr = wr & hit_disp & sel_i[0];
  wire ctrl_en_next = ctrl_wr ? dat_i[SLCD_CTRL_EN_BIT] : ctrl_en_reg;
  wire [SLCD_BLINK_W-1:0] blink_divider_next =
    disp_hi_wr ? dat_i[SLCD_BLINK_LSB +: SLCD_BLINK_W] : blink_divider_reg;
  wire [SLCD_STYLE_W-1:0] style_next =
    disp_lo_wr ? dat_i[SLCD_STYLE_LSB +: SLCD_STYLE_W] : style_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_en_reg <= SLCD_CTRL_EN_RST;
    end else begin
      ctrl_en_reg <= ctrl_en_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blink_divider_reg <= SLCD_BLINK_RST;
    end else begin
      blink_divider_reg <= blink_divider_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      style_reg <= SLCD_STYLE_RST;
    end else begin
      style_reg <= style_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable state and events
  // Disable is seen one cycle after the request drops, while still enabled
  wire disable_event = enabled_state_reg & ~ctrl_en_reg;
  // Frames of a disabled controller raise no flag
  wire frame_event = frame_end_i & enabled_state_reg;
  wire [1:0] events = {disable_event, frame_event};
  wire [1:0] pend_keep = pend_read ? 2'h0 : pend_reg;
  wire enabled_state_next = ctrl_en_reg;
  // ones act, zeros leave enables alone
  wire [1:0] mask_next = (mask_reg | set_bits) & ~clr_bits;
  // sticky until read, a new event wins over the read
  wire [1:0] pend_next = pend_keep | events;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enabled_state_reg <= 1'b0;
    end else begin
      enabled_state_reg <= enabled_state_next;
    end
  end

  // masks and flags clear at reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_reg <= SLCD_IRQ_RST;
    end else begin
      mask_reg <= mask_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_reg <= SLCD_IRQ_RST;
    end else begin
      pend_reg <= pend_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Blink divider
  wire [SLCD_BLINK_W-1:0] cnt_inc = frame_cnt_reg + 8'h01;
  // zero stops blinking, pattern shown steadily
  wire blink_off = (blink_divider_reg == 8'h00);
  wire wrap = (cnt_inc >= blink_divider_reg);
  wire [SLCD_BLINK_W-1:0] frame_cnt_next = (blink_off || wrap) ? 8'h00 : cnt_inc;
  wire phase_next = blink_off ? 1'b0 : (wrap ? ~phase_reg : phase_reg);

  // settings change only on a frame boundary
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      style_active_reg <= SLCD_STYLE_RST;
    end else if (frame_end_i) begin
      style_active_reg <= style_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_cnt_reg <= 8'h00;
    end else if (frame_end_i) begin
      frame_cnt_reg <= frame_cnt_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_reg <= 1'b0;
    end else if (frame_end_i) begin
      phase_reg <= phase_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Segment output
  // Disabled glass stays dark whatever style is latched
  // blink styles alternate with off
  wire [SLCD_SEG_W-1:0] seg_next =
    enabled_state_reg ? styled(style_active_reg, phase_reg, seg_data_i) : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seg_reg <= '0;
    end else begin
      seg_reg <= seg_next;
    end
  end

  assign dat_o = rdata_reg;
  assign ack_o = ack_reg;
  assign seg_out_o = seg_reg;
  assign blink_phase_o = phase_reg;
  assign enabled_o = enabled_state_reg;
  // flagged and enabled source raises the line
  assign irq_o = |(pend_reg & mask_reg);

endmodule

// ### verification/slcd_status_irq_chk.sv
// Port-level assertions for the LCD status and interrupt block
`timescale 1ns/1ps
module slcd_status_irq_chk
  import slcd_pkg::*;
(
  // Clock and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [SLCD_ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [SLCD_DAT_W-1:0] dat_i,
  input wire logic [SLCD_DAT_W-1:0] dat_o,
  input wire logic ack_o,
  // Display and interrupt
  input wire logic frame_end_i,
  input wire logic [SLCD_SEG_W-1:0] seg_data_i,
  input wire logic [SLCD_SEG_W-1:0] seg_out_o,
  input wire logic blink_phase_o,
  input wire logic enabled_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = cyc_i && stb_i && !ack_o;
  sequence s_rd(a);
    req && !we_i && adr_i == a;
  endsequence
  sequence s_on;
    req && we_i && adr_i == SLCD_OFF_CONTROL && sel_i[0] && dat_i[0];
  endsequence
  ////////////////////////////////////////
  a_ack_next: assert property (req |=> ack_o) else $error("ack missing");
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
  a_dat_idle: assert property (!ack_o |-> dat_o == 0) else $error("data not zero");
  a_reset_quiet: assert property ($fell(rst_i) |-> !irq_o && !enabled_o)
    else $error("busy after reset");
  a_state_read: assert property (s_rd(SLCD_OFF_STATE) |=> dat_o == 32'($past(enabled_o)))
    else $error("state read wrong");
  a_wo_zero: assert property (s_rd(SLCD_OFF_IRQ_SET) or s_rd(SLCD_OFF_IRQ_CLR) |=> dat_o == 0)
    else $error("write-only reads nonzero");
  a_enable_seen: assert property (s_on |-> ##[1:2] enabled_o)
    else $error("enable not shown");
  a_irq_hold: assert property (irq_o && !req |=> irq_o)
    else $error("irq dropped without access");
  a_seg_dark: assert property (!enabled_o && !$past(enabled_o) |-> seg_out_o == 0)
    else $error("segments lit while off");
  a_blink_frame: assert property ($changed(blink_phase_o) |-> $past(frame_end_i)
    || $past(frame_end_i, 2)) else $error("phase moved mid-frame");
endmodule
bind slcd_status_irq slcd_status_irq_chk u_chk (.*);

// ### verification/tb_slcd_status_irq.sv
// Self-checking bench for the LCD status and interrupt block
`timescale 1ns/1ps
module tb_slcd_status_irq;
  import slcd_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic frame_end_i = 1'b0, ack_o, blink_phase_o, enabled_o, irq_o, ph = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [39:0] seg_data_i = 40'hff00ff00ff, seg_out_o;
  int err_total = 0, comparisons = 0, cyc_n = 0, flips = 0;
  slcd_status_irq dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .frame_end_i(frame_end_i), .seg_data_i(seg_data_i), .seg_out_o(seg_out_o),
    .blink_phase_o(blink_phase_o), .enabled_o(enabled_o), .irq_o(irq_o)
  );
  always #4 clk_i = ~clk_i;
  // Run is under two hundred cycles; the watchdog at cycle 3000 counts an error and ends it
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      err_total++;
      finish_test();
    end
  end
  ////////////////////////////////////////
  task chk(input logic [39:0] s, input logic [39:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task frame();
    frame_end_i <= 1'b1;
    @(posedge clk_i);
    frame_end_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    if (blink_phase_o !== ph) flips++;
    ph = blink_phase_o;
    if (ph) chk(seg_out_o, 40'h0);
  endtask
  task finish_test();
    $display("Mismatches %0d of %0d checks", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rchk(SLCD_OFF_STATE, 32'h0);
    rchk(SLCD_OFF_IRQ_MASK, 32'h0);
    rchk(SLCD_OFF_IRQ_PEND, 32'h0);
    rchk(8'h1c, 32'h0);
    wb(1'b1, SLCD_OFF_IRQ_SET, 32'h5);
    rchk(SLCD_OFF_IRQ_MASK, 32'h5);
    wb(1'b1, SLCD_OFF_IRQ_CLR, 32'h1);
    rchk(SLCD_OFF_IRQ_MASK, 32'h4);
    wb(1'b1, SLCD_OFF_IRQ_SET, 32'h0);
    wb(1'b1, SLCD_OFF_IRQ_CLR, 32'h0);
    rchk(SLCD_OFF_IRQ_MASK, 32'h4);
    rchk(SLCD_OFF_IRQ_CLR, 32'h0);
    wb(1'b1, SLCD_OFF_IRQ_SET, 32'h1);
    wb(1'b1, SLCD_OFF_CONTROL, 32'h1);
    rchk(SLCD_OFF_STATE, 32'h1);
    chk(irq_o, 1'b0);
    frame();
    chk(irq_o, 1'b1);
    rchk(SLCD_OFF_IRQ_PEND, 32'h1);
    rchk(SLCD_OFF_IRQ_PEND, 32'h0);
    chk(irq_o, 1'b0);
    wb(1'b1, SLCD_OFF_DISPLAY, 32'h0000_0203);
    chk(blink_phase_o, 1'b0);
    ph = 1'b0;
    repeat (4) frame();
    chk(flips, 2);
    chk(seg_out_o, seg_data_i);
    wb(1'b1, SLCD_OFF_DISPLAY, 32'h0000_0003);
    frame();
    flips = 0;
    repeat (3) frame();
    chk({flips[0], blink_phase_o}, 2'h0);
    wb(1'b1, SLCD_OFF_DISPLAY, 32'h0000_0004);
    chk(seg_out_o, seg_data_i);
    frame();
    chk(seg_out_o, ~seg_data_i);
    wb(1'b1, SLCD_OFF_DISPLAY, 32'h0000_0105);
    frame();
    chk(blink_phase_o, 1'b1);
    frame();
    chk(seg_out_o, ~seg_data_i);
    rchk(SLCD_OFF_IRQ_PEND, 32'h1);
    wb(1'b1, SLCD_OFF_CONTROL, 32'h0);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b1);
    rchk(SLCD_OFF_STATE, 32'h0);
    rchk(SLCD_OFF_IRQ_PEND, 32'h4);
    rchk(SLCD_OFF_IRQ_PEND, 32'h0);
    finish_test();
  end
endmodule
